// ===== pkg/ssid_pkg.sv
// Function
// - EEPROM answers target address 1010000; every upload access uses it.
// - Single read: START, 0xA0, address, START, 0xA1, data, NACK, STOP.
// - Random access: control plus address written without STOP, then read.
// - EEPROM stays reachable through the hardware or software serial modes.
// - Right after reset release the block seizes the serial controller.
// - One four-byte sequential read at 100 kHz from byte address 0xFC.
// - Byte at 0xFC lands in subsystem ID 15:8, next in 7:0, in order.
// - 0xFD, 0xFE, 0xFF load ID 7:0, vendor ID 15:8, vendor ID 7:0.
// - Master acks first three data bytes, NACKs the fourth, then STOP.
// - Any missing slave ack abandons upload; identifier field reads zero.
// - Config access to the field before it is updated gets a retry.
// - A normal upload takes about 660 microseconds to store the value.
// - Without EEPROM the field stays zero; firmware may then write it.
// - Field is read-only to config writes unless the write enable is set.
package ssid_pkg;

   // ==========================================================
   // Timing
   localparam int CLK_MHZ     = 100;
   localparam int I2C_KHZ     = 100;
   // Quarter of a bit period, a least time, so rounded up
   localparam int QUARTER_CYC =
      (CLK_MHZ * 1000 + I2C_KHZ * 4 - 1) / (I2C_KHZ * 4);
   localparam int UPLOAD_US   = 660;
   localparam int UPLOAD_CYC  = UPLOAD_US * CLK_MHZ;

   // ==========================================================
   // Addresses and values
   localparam logic [7:0]  SSID_OFFSET  = 8'h20;
   localparam logic [6:0]  EE_TARGET    = 7'h50;
   localparam logic [7:0]  CTRL_WRITE   = {EE_TARGET, 1'b0};
   localparam logic [7:0]  CTRL_READ    = {EE_TARGET, 1'b1};
   localparam logic [7:0]  EE_FIRST     = 8'hFC;
   localparam logic [1:0]  LAST_BYTE    = 2'h3;
   localparam logic [3:0]  ACK_BIT      = 4'h8;
   localparam logic [31:0] SSID_RESET   = 32'h0000_0000;

   // ==========================================================
   // Types
   typedef enum logic [1:0] {
      OP_START = 2'h0,
      OP_STOP  = 2'h1,
      OP_WRITE = 2'h2,
      OP_READ  = 2'h3
   } ssid_op_type;

   typedef struct packed {
      ssid_op_type op;
      logic        data;
   } ssid_cmd_type;

   typedef struct packed {
      logic        req;
      logic        we;
      logic [7:0]  addr;
      logic [3:0]  be;
      logic [31:0] wdata;
   } ssid_cfg_req_type;

   typedef struct packed {
      logic        ack;
      logic        retry;
      logic [31:0] rdata;
   } ssid_cfg_rsp_type;

endpackage

// ===== rtl/ssid_sync.sv
`timescale 1ns/10ps
module ssid_sync #(
   parameter int WIDTH = 2
) (
   // Clock and reset
   input  wire logic             clk,
   input  wire logic             rst_n,
   // Pins in, samples out
   input  wire logic [WIDTH-1:0] async_in,
   output logic      [WIDTH-1:0] sync_out
);
   import ssid_pkg::*;

   logic [WIDTH-1:0] stage;

   // Idle bus lines float high, so reset to ones
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         stage    <= '1;
         sync_out <= '1;
      end else begin
         stage    <= async_in;
         sync_out <= stage;
      end
   end
endmodule

// ===== rtl/ssid_bit_engine.sv
`timescale 1ns/10ps
module ssid_bit_engine #(
   parameter int QUARTER = ssid_pkg::QUARTER_CYC
) (
   // Clock and reset
   input  wire logic                   clk,
   input  wire logic                   rst_n,
   // Command side
   input  wire logic                   cmd_go,
   input  wire ssid_pkg::ssid_cmd_type cmd,
   output logic                        ready,
   output logic                        done,
   output logic                        rx_bit,
   // Bus side, 1 releases the line
   input  wire logic                   scl_seen,
   input  wire logic                   sda_seen,
   output logic                        scl_rel,
   output logic                        sda_rel
);
   import ssid_pkg::*;

   localparam int CW = $clog2(QUARTER + 1);

   generate
      if (QUARTER < 2) begin : g_bad
         $error("QUARTER must be at least 2");
      end
   endgenerate

   // {scl, sda} for each quarter of one bus symbol
   function automatic logic [1:0] levels(ssid_op_type op, logic d,
                                         logic [1:0] ph);
      logic sclv;
      sclv = (ph == 2'h1) || (ph == 2'h2);
      case (op)
         OP_START: levels = {ph != 2'h0 && ph != 2'h3, ph[1] == 1'b0};
         OP_STOP:  levels = {ph != 2'h0, ph[1]};
         OP_WRITE: levels = {sclv, d};
         OP_READ:  levels = {sclv, 1'b1};
         default:  levels = 2'h3;
      endcase
   endfunction

   logic               busy;
   logic [1:0]         phase;
   logic [CW-1:0]      cnt;
   ssid_cmd_type       cur;
   wire  [1:0]         lv       = levels(cur.op, cur.data, phase);
   wire                at_end   = (cnt == CW'(QUARTER - 1));
   // Slave may stretch a released clock; wait until it is seen high
   wire                stall    = lv[1] && !scl_seen;
   wire                step     = busy && at_end && !stall;

   assign ready = !busy;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         busy    <= 1'b0;
         phase   <= 2'h0;
         cnt     <= '0;
         cur     <= '{op: OP_STOP, data: 1'b1};
         done    <= 1'b0;
         rx_bit  <= 1'b1;
         scl_rel <= 1'b1;
         sda_rel <= 1'b1;
      end else begin
         done <= step && (phase == 2'h3);
         if (cmd_go && !busy) begin
            busy  <= 1'b1;
            phase <= 2'h0;
            cnt   <= '0;
            cur   <= cmd;
         end else if (busy) begin
            scl_rel <= lv[1];
            sda_rel <= lv[0];
            if (step) begin
               cnt   <= '0;
               phase <= phase + 2'h1;
               busy  <= (phase != 2'h3);
            end else if (!at_end) begin
               cnt <= cnt + CW'(1);
            end
            // Sample data at the end of the second clock-high quarter
            if (step && phase == 2'h2) begin
               rx_bit <= sda_seen;
            end
         end
      end
   end
endmodule

// ===== rtl/ssid_upload.sv
`timescale 1ns/10ps
module ssid_upload #(
   parameter int QUARTER   = ssid_pkg::QUARTER_CYC,
   parameter int LIMIT_CYC = 2 * ssid_pkg::UPLOAD_CYC
) (
   // Clock and reset
   input  wire logic                       clk,
   input  wire logic                       rst_n,
   // Configuration access
   input  wire ssid_pkg::ssid_cfg_req_type cfg_req,
   output ssid_pkg::ssid_cfg_rsp_type      cfg_rsp,
   input  wire logic                       ssid_wr_en,
   // Software serial controller, same clock
   input  wire logic                       sw_scl_oe_n,
   input  wire logic                       sw_sda_oe_n,
   output logic                            sw_grant,
   output logic                            scl_seen,
   output logic                            sda_seen,
   // Serial bus pins, open drain
   input  wire logic                       scl_in,
   output logic                            scl_out,
   output logic                            scl_oe_n,
   input  wire logic                       sda_in,
   output logic                            sda_out,
   output logic                            sda_oe_n,
   // Status
   output logic                            upload_ok
);
   import ssid_pkg::*;

   localparam int LW = $clog2(LIMIT_CYC + 1);

   generate
      if (LIMIT_CYC < 4 * QUARTER) begin : g_bad
         $error("LIMIT_CYC too short for one bus symbol");
      end
      // Below two cycles the stall test reads a stale clock level
      if (QUARTER < 2) begin : g_short
         $error("QUARTER too short for the pin synchroniser");
      end
   endgenerate

   // ==========================================================
   // Upload states
   typedef enum logic [6:0] {
      ST_IDLE  = 7'h01,
      ST_START = 7'h02,
      ST_TX    = 7'h04,
      ST_RX    = 7'h08,
      ST_STOP  = 7'h10,
      ST_DONE  = 7'h20,
      ST_HAND  = 7'h40
   } ssid_state_type;

   // ==========================================================
   // Pin sampling
   logic [1:0] seen;

   ssid_sync #(
      .WIDTH    (2)
   ) u_sync (
      .clk      (clk),
      .rst_n    (rst_n),
      .async_in ({scl_in, sda_in}),
      .sync_out (seen)
   );

   assign scl_seen = seen[1];
   assign sda_seen = seen[0];

   // ==========================================================
   // Bit engine
   ssid_state_type state;
   ssid_cmd_type   cmd;
   logic           issued;
   logic           eng_ready;
   logic           eng_done;
   logic           eng_rx;
   logic           eng_scl;
   logic           eng_sda;
   logic [1:0]     tx_idx;
   logic [1:0]     rx_idx;
   logic [3:0]     bit_idx;
   logic [7:0]     shreg;
   logic [31:0]    id_acc;
   logic [31:0]    ssid;
   logic           failed;
   logic           loaded;
   logic [LW-1:0]  watch;

   wire active = (state == ST_START) || (state == ST_TX) ||
                 (state == ST_RX) || (state == ST_STOP);
   wire go     = active && eng_ready && !issued && !eng_done;

   ssid_bit_engine #(
      .QUARTER  (QUARTER)
   ) u_engine (
      .clk      (clk),
      .rst_n    (rst_n),
      .cmd_go   (go),
      .cmd      (cmd),
      .ready    (eng_ready),
      .done     (eng_done),
      .rx_bit   (eng_rx),
      .scl_seen (seen[1]),
      .sda_seen (seen[0]),
      .scl_rel  (eng_scl),
      .sda_rel  (eng_sda)
   );

   // ==========================================================
   // Byte decode
   function automatic logic [7:0] tx_byte(logic [1:0] idx);
      case (idx)
         2'h0:    tx_byte = CTRL_WRITE;
         2'h1:    tx_byte = EE_FIRST;
         2'h2:    tx_byte = CTRL_READ;
         default: tx_byte = CTRL_READ;
      endcase
   endfunction

   wire [7:0] cur_tx   = tx_byte(tx_idx);
   wire       in_ack   = (bit_idx == ACK_BIT);
   wire       last_rx  = (rx_idx == LAST_BYTE);
   wire [2:0] bit_sel  = 3'(4'h7 - bit_idx);
   // Master acks bytes 0..2 and NACKs the fourth
   wire       mack     = last_rx;
   wire       slave_nk = (state == ST_TX) && in_ack && eng_rx;
   wire       timeout  = (watch == LW'(LIMIT_CYC));

   // ==========================================================
   // Symbol ends
   wire       bit_end  = eng_done && (state == ST_TX || state == ST_RX);
   wire       ack_end  = bit_end && in_ack;
   // Own last data bit lingers in eng_rx until the ack is sampled
   wire       nack_end = eng_done && slave_nk;

   always_comb begin
      cmd = '{op: OP_STOP, data: 1'b1};
      case (state)
         ST_START: cmd = '{op: OP_START, data: 1'b1};
         ST_TX:    cmd = in_ack ? '{op: OP_READ, data: 1'b1}
                                : '{op: OP_WRITE, data: cur_tx[bit_sel]};
         ST_RX:    cmd = in_ack ? '{op: OP_WRITE, data: mack}
                                : '{op: OP_READ, data: 1'b1};
         default:  cmd = '{op: OP_STOP, data: 1'b1};
      endcase
   end

   // ==========================================================
   // Upload sequencer
   ssid_state_type next_state;

   always_comb begin
      next_state = state;
      case (state)
         ST_IDLE:  next_state = ST_START;
         ST_START: if (eng_done) begin
            next_state = ST_TX;
         end
         ST_TX:    if (eng_done && in_ack) begin
            if (slave_nk) begin
               next_state = ST_STOP;
            end else if (tx_idx == 2'h1) begin
               next_state = ST_START;
            end else if (tx_idx == 2'h2) begin
               next_state = ST_RX;
            end
         end
         ST_RX:    if (eng_done && in_ack && last_rx) begin
            next_state = ST_STOP;
         end
         ST_STOP:  if (eng_done) begin
            next_state = ST_DONE;
         end
         ST_DONE:  next_state = ST_HAND;
         ST_HAND:  next_state = ST_HAND;
         default:  next_state = ST_IDLE;
      endcase
      // A stuck bus must not retry config access forever
      if (active && timeout) begin
         next_state = ST_DONE;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // ==========================================================
   // Issue handshake and watchdog
   // Counts bus time only, so slow config polling cannot trip it
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         issued <= 1'b0;
         watch  <= '0;
      end else begin
         issued <= go || (issued && !eng_done);
         if (active && !timeout) begin
            watch <= watch + LW'(1);
         end
      end
   end

   // Counters and data path
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         tx_idx  <= 2'h0;
         rx_idx  <= 2'h0;
         bit_idx <= 4'h0;
         shreg   <= 8'h00;
         id_acc  <= SSID_RESET;
         failed  <= 1'b0;
      end else begin
         if (bit_end) begin
            bit_idx <= in_ack ? 4'h0 : bit_idx + 4'h1;
         end
         if (ack_end && state == ST_TX && !slave_nk) begin
            tx_idx <= tx_idx + 2'h1;
         end
         if (bit_end && state == ST_RX && !in_ack) begin
            shreg <= {shreg[6:0], eng_rx};
         end
         // First byte ends in bits 31:24, last in 7:0
         if (ack_end && state == ST_RX) begin
            id_acc <= {id_acc[23:0], shreg};
            rx_idx <= rx_idx + 2'h1;
         end
         if (nack_end || (active && timeout)) begin
            failed <= 1'b1;
         end
      end
   end

   // ==========================================================
   // Identifier register and config port
   wire cfg_hit  = cfg_req.req && (cfg_req.addr == SSID_OFFSET);
   wire cfg_wr   = cfg_hit && cfg_req.we && loaded && ssid_wr_en;
   wire commit   = (state == ST_DONE);
   wire [31:0] next_ssid = failed ? SSID_RESET : id_acc;
   // Reads return data only once the field is settled
   wire cfg_early = cfg_hit && !loaded;
   wire cfg_rd    = cfg_hit && loaded && !cfg_req.we;

   function automatic logic [31:0] merge(logic [31:0] old,
                                         logic [31:0] nv,
                                         logic [3:0]  be);
      for (int i = 0; i < 4; i++) begin
         merge[i*8 +: 8] = be[i] ? nv[i*8 +: 8] : old[i*8 +: 8];
      end
   endfunction

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         ssid      <= SSID_RESET;
         loaded    <= 1'b0;
         upload_ok <= 1'b0;
      end else begin
         if (commit) begin
            ssid      <= next_ssid;
            loaded    <= 1'b1;
            upload_ok <= !failed;
         end else if (cfg_wr) begin
            ssid <= merge(ssid, cfg_req.wdata, cfg_req.be);
         end
      end
   end

   // Early access to the field is retried, never stalled
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         cfg_rsp <= '0;
      end else begin
         cfg_rsp.ack   <= cfg_req.req && !cfg_early;
         cfg_rsp.retry <= cfg_early;
         cfg_rsp.rdata <= cfg_rd ? ssid : '0;
      end
   end

   // ==========================================================
   // Pin ownership
   // Software pulls reach the pins only once the field is settled
   wire scl_pick = loaded ? sw_scl_oe_n : eng_scl;
   wire sda_pick = loaded ? sw_sda_oe_n : eng_sda;

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         sw_grant <= 1'b0;
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         scl_oe_n <= 1'b1;
         sda_oe_n <= 1'b1;
      end else begin
         sw_grant <= loaded;
         scl_out  <= 1'b0;
         sda_out  <= 1'b0;
         scl_oe_n <= scl_pick;
         sda_oe_n <= sda_pick;
      end
   end
endmodule

// ===== verification/ssid_monitor.sv
`timescale 1ns/10ps
// ==========================================
// Port checker for the identifier upload
module ssid_monitor #(
   parameter int QUARTER   = 4,
   parameter int LIMIT_CYC = 1000
) (
   // Clock and reset
   input wire logic                       clk,
   input wire logic                       rst_n,
   // Config port
   input wire ssid_pkg::ssid_cfg_req_type cfg_req,
   input wire ssid_pkg::ssid_cfg_rsp_type cfg_rsp,
   // Serial pins and hand-over
   input wire logic                       sw_sda_oe_n,
   input wire logic                       sw_grant,
   input wire logic                       scl_out,
   input wire logic                       scl_oe_n,
   input wire logic                       sda_out,
   input wire logic                       sda_oe_n,
   input wire logic                       upload_ok
);
   import ssid_pkg::*;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // ==========================================
   // Config answers
   a_resp_once: assert property (
      cfg_req.req |=> cfg_rsp.ack != cfg_rsp.retry)
      else $error("Config request not answered once");
   a_resp_cause: assert property (
      !cfg_req.req |=> !cfg_rsp.ack && !cfg_rsp.retry)
      else $error("Config answer without request");
   a_loaded_acks: assert property (
      cfg_req.req && upload_ok |=> cfg_rsp.ack)
      else $error("Retry after a finished upload");
   a_other_zero: assert property (
      cfg_req.req && cfg_req.addr != SSID_OFFSET
      |=> cfg_rsp.ack && cfg_rsp.rdata == 32'h0000_0000)
      else $error("Foreign offset not read as zero");
   // ==========================================
   // Serial pins
   a_pins_open: assert property (
      !scl_out && !sda_out)
      else $error("Pin driven high");
   a_scl_low: assert property (
      $fell(scl_oe_n) && !sw_grant |-> !scl_oe_n [*2])
      else $error("Clock low phase too short");
   a_ok_idle: assert property (
      $rose(upload_ok) |-> $past(scl_oe_n) && $past(sda_oe_n))
      else $error("Upload stored before stop");
   a_ok_grant: assert property (
      $rose(upload_ok) |-> ##[0:2] sw_grant)
      else $error("Pins not handed back");
   a_sw_pass: assert property (
      sw_grant && $past(sw_grant) && !$past(sw_sda_oe_n) |-> !sda_oe_n)
      else $error("Software pull not on pin");
   c_retry: cover property (cfg_rsp.retry);
   c_loaded: cover property (cfg_rsp.ack && upload_ok);
   c_abort: cover property (sw_grant && !upload_ok);
endmodule

bind ssid_upload ssid_monitor #(.QUARTER(QUARTER), .LIMIT_CYC(LIMIT_CYC))
   mon (.clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
   .sw_sda_oe_n(sw_sda_oe_n), .sw_grant(sw_grant), .scl_out(scl_out),
   .scl_oe_n(scl_oe_n), .sda_out(sda_out), .sda_oe_n(sda_oe_n),
   .upload_ok(upload_ok));

// ===== verification/ssid_eeprom_model.sv
`timescale 1ns/10ps
// ==========================================
// Serial EEPROM model, 256 bytes
module ssid_eeprom_model (
   // Bus wires, 1 releases
   input  wire logic        scl,
   input  wire logic        sda,
   output logic             scl_rel,
   output logic             sda_rel,
   // Behaviour, nack_at 3 refuses no byte of the upload sequence
   input  wire logic        present,
   input  wire logic [1:0]  nack_at,
   input  wire logic [11:0] stretch,
   input  wire logic [31:0] top_bytes,
   // Data bytes sent before the last stop
   output logic [3:0]       stop_rd
);
   logic [7:0] sh, ptr, bno;
   logic [3:0] bitc, n_rd;
   logic       act, rd, ackd, mack;
   initial begin
      scl_rel = 1'b1;
      sda_rel = 1'b1;
      act = 1'b0;
      stop_rd = 4'h0;
   end
   // ==========================================
   // Start and stop: data edges with clock high
   always @(negedge sda) begin
      if (scl) begin
         act = 1'b1;
         {rd, ackd, bitc, bno, n_rd} = '0;
      end
   end
   always @(posedge sda) begin
      if (scl) begin
         act = 1'b0;
         stop_rd = n_rd;
      end
   end
   // ==========================================
   // Bits: sample on rise, drive on fall
   always @(posedge scl) begin
      if (act && bitc < 4'h8) begin
         sh = {sh[6:0], sda};
         bitc = bitc + 4'h1;
      end else if (act && rd) mack = !sda;
   end
   always @(negedge scl) begin
      if (act && bitc == 4'h8 && !ackd) begin
         ackd = 1'b1;
         if (rd) sda_rel = 1'b1;
         else if (!present || (bno == 8'h00 && sh[7:1] != 7'h50)
            || nack_at == ((bno == 8'h00 && sh[0]) ? 2'h2 : bno[1:0]))
            act = 1'b0;
         else begin
            sda_rel = 1'b0;
            if (bno == 8'h01) ptr = sh;
            if (bno == 8'h00) rd = sh[0];
            bno = bno + 8'h01;
            mack = 1'b1;
         end
      end else if (act && bitc == 4'h8) begin
         ackd = 1'b0;
         bitc = 4'h0;
         // Sequential read walks on while the master acks
         if (rd && mack) begin
            sh = (ptr >= 8'hFC) ? top_bytes[8 * (8'hFF - ptr) +: 8]
                                : ptr ^ 8'h5A;
            ptr = ptr + 8'h01;
            n_rd = n_rd + 4'h1;
         end else rd = 1'b0;
         sda_rel = rd ? sh[7] : 1'b1;
      end else if (act && rd) sda_rel = sh[7];
      else if (!act) sda_rel = 1'b1;
      // Slow device holds the clock low
      if (stretch != 12'h000) begin
         scl_rel = 1'b0;
         #(stretch * 10);
         scl_rel = 1'b1;
      end
   end
endmodule

// ===== verification/tb_top.sv
`timescale 1ns/10ps
// ==========================================
// Bench for the identifier upload
module tb_top;
   import ssid_pkg::*;
   localparam int QRT = 2;
   localparam int LIM = 1500;
   logic             clk, rst_n, ssid_wr_en, sw_scl_oe_n, sw_sda_oe_n;
   ssid_cfg_req_type cfg_req;
   ssid_cfg_rsp_type cfg_rsp;
   logic             sw_grant, scl_seen, sda_seen, upload_ok;
   logic             scl_out, scl_oe_n, sda_out, sda_oe_n;
   logic             scl, sda, ee_scl_rel, ee_sda_rel, present;
   logic [1:0]       nack_at;
   logic [11:0]      stretch;
   logic [31:0]      top_bytes, field;
   logic [3:0]       stop_rd;
   int               seed = 44;
   int               error_cnt = 0;
   int               n_compared = 0;
   // Open drain wires with pull-up
   assign scl = (scl_oe_n | scl_out) & ee_scl_rel;
   assign sda = (sda_oe_n | sda_out) & ee_sda_rel;
   initial clk = 1'b0;
   always #5 clk = ~clk;
   ssid_upload #(.QUARTER(QRT), .LIMIT_CYC(LIM)) uut (
      .clk(clk), .rst_n(rst_n), .cfg_req(cfg_req), .cfg_rsp(cfg_rsp),
      .ssid_wr_en(ssid_wr_en), .sw_scl_oe_n(sw_scl_oe_n),
      .sw_sda_oe_n(sw_sda_oe_n), .sw_grant(sw_grant),
      .scl_seen(scl_seen), .sda_seen(sda_seen), .scl_in(scl),
      .scl_out(scl_out), .scl_oe_n(scl_oe_n), .sda_in(sda),
      .sda_out(sda_out), .sda_oe_n(sda_oe_n), .upload_ok(upload_ok));
   ssid_eeprom_model ee (
      .scl(scl), .sda(sda), .scl_rel(ee_scl_rel), .sda_rel(ee_sda_rel),
      .present(present), .nack_at(nack_at), .stretch(stretch),
      .top_bytes(top_bytes), .stop_rd(stop_rd));
   // ==========================================
   // Helpers
   function automatic logic [31:0] merge(input logic [31:0] o, n,
                                         input logic [3:0]  be);
      for (int i = 0; i < 4; i++)
         if (be[i]) o[8 * i +: 8] = n[8 * i +: 8];
      return o;
   endfunction
   task automatic chk(input string nm, input logic [31:0] e, g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic complete_run;
      $display("Compared %0d, mismatches %0d", n_compared, error_cnt);
      if (error_cnt == 0 && n_compared > 0) $display("All tests passed");
      else $display("Some tests failed");
      $finish;
   endtask
   task automatic cfg(input logic we, input logic [7:0] a,
                      input logic [3:0] be, input logic [31:0] wd,
                      output logic [1:0] r);
      @(posedge clk);
      cfg_req <= '{1'b1, we, a, be, wd};
      @(posedge clk);
      cfg_req.req <= 1'b0;
      @(negedge clk);
      r = {cfg_rsp.ack, cfg_rsp.retry};
      field = cfg_rsp.rdata;
   endtask
   // Software pulls both lines from reset on; it must wait its turn
   task automatic do_reset(input logic p, input logic [1:0] na,
                           input logic [11:0] st);
      @(posedge clk);
      rst_n <= 1'b0;
      {present, nack_at, stretch} <= {p, na, st};
      top_bytes <= $random(seed);
      {sw_scl_oe_n, sw_sda_oe_n} <= 2'b00;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
   endtask
   task automatic wait_load(output int nr, output int cyc);
      logic [1:0] r;
      {nr, cyc, r} = '0;
      while (r !== 2'b10 && cyc < 3 * LIM) begin
         cfg(1'b0, SSID_OFFSET, 4'h0, 32'h0, r);
         cyc += 3;
         if (r === 2'b01) nr++;
      end
      if (r !== 2'b10) begin
         error_cnt++;
         $display("BAD load wait expected 2 seen %h", r);
         complete_run;
      end
   endtask
   task automatic wtest(input logic [31:0] v);
      logic [1:0]  r;
      logic [31:0] w;
      logic [3:0]  be;
      w = $random(seed);
      be = $random(seed);
      cfg(1'b1, SSID_OFFSET, 4'hF, ~v, r);
      chk("locked write", 32'h2, {30'h0, r});
      cfg(1'b0, SSID_OFFSET, 4'h0, 32'h0, r);
      chk("locked field", v, field);
      @(posedge clk) ssid_wr_en <= 1'b1;
      cfg(1'b1, SSID_OFFSET, be, w, r);
      @(posedge clk) ssid_wr_en <= 1'b0;
      cfg(1'b0, SSID_OFFSET, 4'h0, 32'h0, r);
      chk("enabled write", merge(v, w, be), field);
      cfg(1'b0, SSID_OFFSET + 8'h04, 4'h0, 32'h0, r);
      chk("other offset", 32'h0, field);
   endtask
   // ==========================================
   // Scenarios
   initial begin
      int nr, cyc;
      {rst_n, ssid_wr_en, present, nack_at, stretch, cfg_req} = '0;
      {sw_scl_oe_n, sw_sda_oe_n, top_bytes} = '1;
      for (int t = 0; t < 2; t++) begin
         do_reset(1'b1, 2'h3, 12'(t));
         wait_load(nr, cyc);
         chk("field", top_bytes, field);
         chk("upload ok", 32'h1, {31'h0, upload_ok});
         chk("retried", 32'h1, {31'h0, nr > 0});
         chk("in time", 32'h1, {31'h0, cyc < LIM});
         chk("bytes read", 32'h4, {28'h0, stop_rd});
         repeat (4) @(negedge clk);
         chk("sw grant", 32'h1, {31'h0, sw_grant});
         chk("sw pins", 32'h0, {30'h0, scl_oe_n, sda_oe_n});
         chk("seen pins", 32'h0, {30'h0, scl_seen, sda_seen});
         @(posedge clk);
         sw_scl_oe_n <= 1'b1;
         @(posedge clk);
         sw_sda_oe_n <= 1'b1;
         wtest(top_bytes);
         chk("idle pins", 32'h3, {30'h0, scl_seen, sda_seen});
         $display("Normal upload %0d done", t);
      end
      // Refusal at each acked byte, then no device at all
      for (int k = 0; k < 4; k++) begin
         do_reset(k < 3, 2'(k), 12'h000);
         wait_load(nr, cyc);
         chk("aborted field", 32'h0, field);
         chk("aborted ok", 32'h0, {31'h0, upload_ok});
         if (k == 3) wtest(32'h0);
         $display("Refusal case %0d done", k);
      end
      // Clock held low past the watchdog
      do_reset(1'b1, 2'h3, 12'd3000);
      wait_load(nr, cyc);
      chk("watchdog field", 32'h0, field);
      chk("watchdog grant", 32'h1, {31'h0, sw_grant});
      $display("Watchdog case done");
      complete_run;
   end
endmodule
